// [src/async_serial_pkg.sv]
package async_serial_pkg;
    // register addresses on the plain port
    localparam logic [2:0] ADDR_MODE = 3'h0;
    localparam logic [2:0] ADDR_STATUS = 3'h1;
    localparam logic [2:0] ADDR_BAUD = 3'h2;
    localparam logic [2:0] ADDR_TX_DATA = 3'h3;
    localparam logic [2:0] ADDR_RX_DATA = 3'h4;
    // mode_control_reg fields
    localparam int MODE_ENABLE_BIT = 15;
    localparam int MODE_LOOPBACK_BIT = 6;
    localparam int MODE_DATA_PARITY_SELECT_LSB = 1;
    localparam int MODE_STOP_BIT = 0;
    localparam logic [15:0] MODE_RESET = 16'h0000;
    localparam logic [15:0] MODE_WMASK = 16'h8047;
    // status_control_reg fields
    localparam int STA_TX_IRQ_SEL_BIT = 15;
    localparam int STA_TX_BREAK_BIT = 11;
    localparam int STA_TX_ENABLE_BIT = 10;
    localparam int STA_TX_FULL_BIT = 9;
    localparam int STA_TX_EMPTY_BIT = 8;
    localparam int STA_RX_IRQ_SEL_LSB = 6;
    localparam int STA_ADDR_DET_BIT = 5;
    localparam int STA_RX_IDLE_BIT = 4;
    localparam int STA_PARITY_ERROR_FLAG_BIT = 3;
    localparam int STA_FRAMING_ERROR_FLAG_BIT = 2;
    localparam int STA_OVERRUN_BIT = 1;
    localparam int STA_RX_AVAIL_BIT = 0;
    localparam logic [15:0] BAUD_RESET = 16'h0000;
    // data/parity select encodings
    localparam logic [1:0] PD_8N = 2'h0;
    localparam logic [1:0] PD_8E = 2'h1;
    localparam logic [1:0] PD_8O = 2'h2;
    localparam logic [1:0] PD_9N = 2'h3;
    // receive interrupt select encodings
    localparam logic [1:0] RXIS_THREE = 2'h2;
    localparam logic [1:0] RXIS_FULL = 2'h3;
    // timing
    localparam int OVERSAMPLE = 16;
    localparam logic [3:0] SUB_LAST = 4'hF;
    localparam logic [3:0] SUB_MID = 4'h7;
    localparam int FIFO_DEPTH_DEF = 4;
    localparam int FRAME_MAX = 12;
endpackage

// [src/async_serial_tx_rx_core.sv]
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ns
// Behaviour
// - free shifter loads written byte at once
// - enabling transmit starts pending data immediately
// - four-deep nine-bit transmit fifo, full flag
// - write to full transmit fifo discarded
// - fifos emptied only by reset or module disable
// - transmit irq on load, select-dependent
// - break bit forces transmit line low
// - break sends no transmit irq
// - data read pops fifo, updates error flags
// - four-word receive fifo, data available flag
// - receive irq on push by fill level
// - overrun when fifo and shifter full
// - overrun halts receiver until software clear
// - framing error on zero stop bit
// - parity error in parity modes only
// - idle flag low during a character
// - long break stores zero word, waits high
// - with address detect on in nine-bit mode, address words always raise receive irq
// - loopback feeds transmitter into receiver
// - data/parity and stop bit selection
// - baud divisor sixteen times divisor plus one
// - module disable flushes and aborts
module async_serial_tx_rx_core
    import async_serial_pkg::*;
#(
    parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input wire logic [2:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [15:0] rdata_out,
    input wire logic rx_pin_in,
    output logic tx_pin_out,
    output logic tx_pin_oe_out,
    output logic tx_irq_out,
    output logic rx_irq_out
);
    localparam int PW = $clog2(FIFO_DEPTH);
    localparam int CW = PW + 1;
    localparam logic [CW-1:0] DEPTH_C = CW'(FIFO_DEPTH);
    localparam logic [CW-1:0] THREE_C = CW'(3);

    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_HOLD, RX_WAIT_HIGH} rx_state_e;

    // frame length after the start bit
    function automatic logic [3:0] frame_bits(input logic [1:0] pd, input logic two_stop);
        frame_bits = 4'd9 + ((pd != PD_8N) ? 4'd1 : 4'd0) + (two_stop ? 4'd1 : 4'd0);
    endfunction

    function automatic logic parity_of(input logic [7:0] d, input logic [1:0] pd);
        parity_of = (^d) ^ (pd == PD_8O);
    endfunction

    logic [15:0] mode_q, baud_q, baud_cnt_q;
    logic tx_irq_sel_q, tx_break_q, tx_enable_q, addr_det_q, overrun_q;
    logic [1:0] rx_irq_sel_q;
    logic [15:0] rdata_q;
    logic [8:0] rx_last_q;
    logic [8:0] tx_mem_q [FIFO_DEPTH];
    logic [PW-1:0] tx_wp_q, tx_rp_q;
    logic [CW-1:0] tx_cnt_q;
    logic [FRAME_MAX-1:0] tx_sh_q;
    logic [3:0] tx_left_q, tx_sub_q;
    logic tx_busy_q, tx_irq_q;
    logic [10:0] rx_mem_q [FIFO_DEPTH];
    logic [PW-1:0] rx_wp_q, rx_rp_q;
    logic [CW-1:0] rx_cnt_q;
    logic [10:0] rx_sh_q;
    logic [3:0] rx_left_q, rx_sub_q;
    logic [10:0] rx_word_q;
    logic rx_sync1_q, rx_sync2_q, rx_prev_q, rx_irq_q;
    rx_state_e rx_state_q;

    wire enable_w = mode_q[MODE_ENABLE_BIT];
    wire loopback_w = mode_q[MODE_LOOPBACK_BIT];
    wire [1:0] data_parity_select_w = mode_q[MODE_DATA_PARITY_SELECT_LSB +: 2];
    wire two_stop_w = mode_q[MODE_STOP_BIT];
    wire nine_w = (data_parity_select_w == PD_9N);
    wire par_en_w = (data_parity_select_w == PD_8E) || (data_parity_select_w == PD_8O);
    wire [3:0] nbits_w = frame_bits(data_parity_select_w, two_stop_w);

    wire wr_mode_w = wr_in && (addr_in == ADDR_MODE);
    wire wr_sta_w = wr_in && (addr_in == ADDR_STATUS);
    wire wr_baud_w = wr_in && (addr_in == ADDR_BAUD);
    wire wr_tx_w = wr_in && (addr_in == ADDR_TX_DATA);
    wire rd_rx_w = rd_in && (addr_in == ADDR_RX_DATA);

    // baud tick every divisor plus one
    wire tick_w = enable_w && (baud_cnt_q == baud_q);

    wire tx_full_w = (tx_cnt_q == DEPTH_C);
    wire tx_empty_w = (tx_cnt_q == '0);
    wire tx_push_w = wr_tx_w && enable_w && !tx_full_w;
    wire tx_load_w = enable_w && tx_enable_q && !tx_break_q && !tx_busy_q && !tx_empty_w;
    wire [8:0] tx_head_w = tx_mem_q[tx_rp_q];
    wire tx_ninth_w = nine_w ? tx_head_w[8] : (par_en_w ? parity_of(tx_head_w[7:0], data_parity_select_w) : 1'b1);
    wire [FRAME_MAX-1:0] tx_frame_w = {2'b11, tx_ninth_w, tx_head_w[7:0], 1'b0};
    wire [CW-1:0] tx_cnt_next_w = tx_cnt_q + CW'(tx_push_w) - CW'(tx_load_w);
    wire tx_irq_set_w = tx_load_w && (!tx_irq_sel_q || tx_cnt_next_w == '0);
    wire tx_line_w = tx_busy_q ? tx_sh_q[0] : 1'b1;

    wire tx_pin_w = tx_break_q ? 1'b0 : tx_line_w;
    wire rx_line_w = loopback_w ? tx_pin_w : rx_sync2_q;

    wire rx_empty_w = (rx_cnt_q == '0);
    wire rx_full_w = (rx_cnt_q == DEPTH_C);
    wire rx_pop_w = rd_rx_w && enable_w && !rx_empty_w;
    wire [10:0] rx_head_w = rx_mem_q[rx_rp_q];

    // received frame aligned to bit 0
    // last sample joins the frame here
    wire [10:0] rx_sh_next_w = {rx_line_w, rx_sh_q[10:1]};
    wire [10:0] rx_frame_w = rx_sh_next_w >> (4'd11 - nbits_w);
    wire [3:0] stop_idx_w = nine_w || par_en_w ? 4'd9 : 4'd8;
    wire stop1_w = rx_frame_w[stop_idx_w];
    wire stop2_w = two_stop_w ? rx_frame_w[stop_idx_w + 4'd1] : 1'b1;
    wire framing_error_flag_w = !(stop1_w && stop2_w);
    wire parity_error_flag_w = par_en_w && (rx_frame_w[8] != parity_of(rx_frame_w[7:0], data_parity_select_w));
    wire rx_b8_w = nine_w ? rx_frame_w[8] : 1'b0;
    wire [10:0] rx_new_w = {parity_error_flag_w, framing_error_flag_w, rx_b8_w, rx_frame_w[7:0]};
    wire rx_break_w = framing_error_flag_w && (rx_frame_w[8:0] == 9'h000);

    wire rx_sample_w = tick_w && (rx_sub_q == SUB_LAST);
    wire rx_done_w = (rx_state_q == RX_DATA) && rx_sample_w && (rx_left_q == 4'd1);
    wire rx_ovf_w = rx_done_w && rx_full_w;
    wire rx_hold_go_w = (rx_state_q == RX_HOLD) && !overrun_q && !rx_full_w;
    wire rx_push_w = (rx_done_w && !rx_full_w) || rx_hold_go_w;
    wire [10:0] rx_push_word_w = rx_done_w ? rx_new_w : rx_word_q;
    wire [CW-1:0] rx_cnt_next_w = rx_cnt_q + CW'(rx_push_w) - CW'(rx_pop_w);
    wire rx_lvl_irq_w = rx_irq_sel_q == RXIS_THREE ? (rx_cnt_next_w == THREE_C) :
                        rx_irq_sel_q == RXIS_FULL ? (rx_cnt_next_w == DEPTH_C) : 1'b1;
    wire rx_irq_set_w = rx_push_w &&
                        ((addr_det_q && nine_w) ? rx_push_word_w[8] : rx_lvl_irq_w);
    wire rx_fall_w = rx_prev_q && !rx_line_w;
    wire rx_idle_w = (rx_state_q == RX_IDLE) || (rx_state_q == RX_WAIT_HIGH);

    wire [15:0] status_w = {tx_irq_sel_q, 3'b000, tx_break_q, tx_enable_q, tx_full_w,
                            !tx_busy_q && tx_empty_w, rx_irq_sel_q, addr_det_q, rx_idle_w,
                            !rx_empty_w && rx_head_w[10], !rx_empty_w && rx_head_w[9],
                            overrun_q, !rx_empty_w};
    wire [15:0] rd_mux_w = addr_in == ADDR_MODE ? mode_q :
                           addr_in == ADDR_STATUS ? status_w :
                           addr_in == ADDR_BAUD ? baud_q :
                           addr_in == ADDR_RX_DATA ? {7'h00, rx_empty_w ? rx_last_q : rx_head_w[8:0]} :
                           16'h0000;

    assign rdata_out = rdata_q;
    assign tx_pin_out = enable_w ? tx_pin_w : 1'b1;
    assign tx_pin_oe_out = enable_w;
    assign tx_irq_out = tx_irq_q;
    assign rx_irq_out = rx_irq_q;

    // register port and control bits
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mode_q <= MODE_RESET;
            baud_q <= BAUD_RESET;
            tx_irq_sel_q <= 1'b0;
            tx_break_q <= 1'b0;
            tx_enable_q <= 1'b0;
            rx_irq_sel_q <= 2'b00;
            addr_det_q <= 1'b0;
            overrun_q <= 1'b0;
            rdata_q <= 16'h0000;
        end else if (ce_in) begin
            if (rd_in) begin
                rdata_q <= rd_mux_w;
            end
            if (wr_mode_w) begin
                mode_q <= wdata_in & MODE_WMASK;
            end
            if (wr_baud_w) begin
                baud_q <= wdata_in;
            end
            if (wr_sta_w) begin
                tx_irq_sel_q <= wdata_in[STA_TX_IRQ_SEL_BIT];
                rx_irq_sel_q <= wdata_in[STA_RX_IRQ_SEL_LSB +: 2];
                addr_det_q <= wdata_in[STA_ADDR_DET_BIT];
                tx_break_q <= enable_w && wdata_in[STA_TX_BREAK_BIT];
                tx_enable_q <= enable_w && wdata_in[STA_TX_ENABLE_BIT];
                if (!wdata_in[STA_OVERRUN_BIT]) begin
                    overrun_q <= 1'b0;
                end
            end
            // set wins over software clear
            if (rx_ovf_w) begin
                overrun_q <= 1'b1;
            end
            if (!enable_w) begin
                tx_break_q <= 1'b0;
                tx_enable_q <= 1'b0;
                overrun_q <= 1'b0;
            end
        end
    end

    // baud counter and receive synchroniser
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            baud_cnt_q <= 16'h0000;
            rx_sync1_q <= 1'b1;
            rx_sync2_q <= 1'b1;
            rx_prev_q <= 1'b1;
        end else if (ce_in) begin
            rx_sync1_q <= rx_pin_in;
            rx_sync2_q <= rx_sync1_q;
            rx_prev_q <= rx_line_w;
            if (!enable_w || tick_w) begin
                baud_cnt_q <= 16'h0000;
            end else begin
                baud_cnt_q <= baud_cnt_q + 16'h0001;
            end
        end
    end

    // transmit fifo and shifter
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tx_wp_q <= '0;
            tx_rp_q <= '0;
            tx_cnt_q <= '0;
            tx_sh_q <= '1;
            tx_left_q <= 4'h0;
            tx_sub_q <= 4'h0;
            tx_busy_q <= 1'b0;
            tx_irq_q <= 1'b0;
        end else if (ce_in) begin
            tx_irq_q <= tx_irq_set_w;
            if (!enable_w) begin
                tx_wp_q <= '0;
                tx_rp_q <= '0;
                tx_cnt_q <= '0;
                tx_busy_q <= 1'b0;
                tx_sub_q <= 4'h0;
            end else begin
                if (tx_push_w) begin
                    tx_mem_q[tx_wp_q] <= wdata_in[8:0];
                    tx_wp_q <= tx_wp_q + PW'(1);
                end
                tx_cnt_q <= tx_cnt_next_w;
                if (tx_load_w) begin
                    tx_rp_q <= tx_rp_q + PW'(1);
                    tx_sh_q <= tx_frame_w;
                    tx_left_q <= nbits_w + 4'd1;
                    tx_sub_q <= 4'h0;
                    tx_busy_q <= 1'b1;
                end else if (tx_busy_q && tick_w) begin
                    tx_sub_q <= tx_sub_q + 4'h1;
                    if (tx_sub_q == SUB_LAST) begin
                        tx_sh_q <= {1'b1, tx_sh_q[FRAME_MAX-1:1]};
                        tx_left_q <= tx_left_q - 4'd1;
                        if (tx_left_q == 4'd1) begin
                            tx_busy_q <= 1'b0;
                        end
                    end
                end
            end
        end
    end

    // receive fifo and shifter
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rx_wp_q <= '0;
            rx_rp_q <= '0;
            rx_cnt_q <= '0;
            rx_sh_q <= 11'h000;
            rx_left_q <= 4'h0;
            rx_sub_q <= 4'h0;
            rx_word_q <= 11'h000;
            rx_last_q <= 9'h000;
            rx_irq_q <= 1'b0;
            rx_state_q <= RX_IDLE;
        end else if (ce_in) begin
            rx_irq_q <= enable_w && rx_irq_set_w;
            if (!enable_w) begin
                rx_wp_q <= '0;
                rx_rp_q <= '0;
                rx_cnt_q <= '0;
                rx_sub_q <= 4'h0;
                rx_state_q <= RX_IDLE;
            end else begin
                if (rx_pop_w) begin
                    rx_rp_q <= rx_rp_q + PW'(1);
                    rx_last_q <= rx_head_w[8:0];
                end
                if (rx_push_w) begin
                    rx_mem_q[rx_wp_q] <= rx_push_word_w;
                    rx_wp_q <= rx_wp_q + PW'(1);
                end
                rx_cnt_q <= rx_cnt_next_w;
                if (tick_w) begin
                    rx_sub_q <= rx_sub_q + 4'h1;
                end
                unique case (rx_state_q)
                    RX_IDLE: begin
                        if (rx_fall_w) begin
                            rx_sub_q <= 4'h0;
                            rx_state_q <= RX_START;
                        end
                    end
                    RX_START: begin
                        if (tick_w && rx_sub_q == SUB_MID) begin
                            rx_sub_q <= 4'h0;
                            rx_left_q <= nbits_w;
                            rx_state_q <= rx_line_w ? RX_IDLE : RX_DATA;
                        end
                    end
                    RX_DATA: begin
                        if (rx_sample_w) begin
                            rx_sh_q <= rx_sh_next_w;
                            rx_left_q <= rx_left_q - 4'd1;
                        end
                        if (rx_ovf_w) begin
                            rx_word_q <= rx_new_w;
                            rx_state_q <= RX_HOLD;
                        end else if (rx_done_w) begin
                            rx_state_q <= rx_break_w ? RX_WAIT_HIGH : RX_IDLE;
                        end
                    end
                    RX_HOLD: begin
                        if (rx_hold_go_w) begin
                            rx_state_q <= RX_IDLE;
                        end
                    end
                    RX_WAIT_HIGH: begin
                        if (rx_line_w) begin
                            rx_state_q <= RX_IDLE;
                        end
                    end
                endcase
            end
        end
    end
endmodule

// [testbench/serial_core_monitor.sv]
`timescale 1ns/1ns
module serial_core_monitor
    import async_serial_pkg::*;
#(
    parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input wire logic [2:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [15:0] rdata_out,
    input wire logic rx_pin_in,
    input wire logic tx_pin_out,
    input wire logic tx_pin_oe_out,
    input wire logic tx_irq_out,
    input wire logic rx_irq_out
);
    logic en_q, brk_q;
    wire logic mode_wr = ce_in && wr_in && (addr_in == ADDR_MODE);
    wire logic sta_wr = ce_in && wr_in && (addr_in == ADDR_STATUS);
    wire logic en_d = mode_wr ? wdata_in[MODE_ENABLE_BIT] : en_q;
    wire logic brk_d = en_d && (sta_wr ? en_q && wdata_in[STA_TX_BREAK_BIT] : brk_q);
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            en_q <= 1'b0;
            brk_q <= 1'b0;
        end else if (ce_in) begin
            en_q <= en_d;
            brk_q <= brk_d;
        end
    end
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_n_in);
    property p_break_low;
        brk_q |-> !tx_pin_out;
    endproperty
    a_break_low: assert property (p_break_low) else $error("line high in break");
    property p_break_quiet;
        brk_q && $past(brk_q) && $past(brk_q, 2) |-> !tx_irq_out;
    endproperty
    a_break_quiet: assert property (p_break_quiet) else $error("tx irq in break");
    property p_oe_follows;
        tx_pin_oe_out == en_q;
    endproperty
    a_oe_follows: assert property (p_oe_follows) else $error("oe not enable");
    property p_off_idle;
        !en_q |-> tx_pin_out;
    endproperty
    a_off_idle: assert property (p_off_idle) else $error("line low when off");
    property p_tx_pulse;
        tx_irq_out |=> !tx_irq_out;
    endproperty
    a_tx_pulse: assert property (p_tx_pulse) else $error("tx irq too long");
    property p_rx_pulse;
        rx_irq_out |=> !rx_irq_out;
    endproperty
    a_rx_pulse: assert property (p_rx_pulse) else $error("rx irq too long");
    property p_start_bit;
        tx_irq_out |-> (!tx_pin_out) [*8];
    endproperty
    a_start_bit: assert property (p_start_bit) else $error("no start bit");
    property p_read_hold;
        !$past(rd_in && ce_in) |-> $stable(rdata_out);
    endproperty
    a_read_hold: assert property (p_read_hold) else $error("read data moved");
    property p_unmapped;
        rd_in && ce_in && (addr_in > ADDR_RX_DATA) |=> rdata_out == 16'h0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped not zero");
    c_tx_irq: cover property (tx_irq_out);
    c_rx_irq: cover property (rx_irq_out);
    c_break: cover property (brk_q);
endmodule
bind async_serial_tx_rx_core serial_core_monitor #(.FIFO_DEPTH(FIFO_DEPTH)) u_monitor (
    .clk_sys_in, .rst_n_in, .ce_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .rx_pin_in, .tx_pin_out, .tx_pin_oe_out, .tx_irq_out, .rx_irq_out);

// [testbench/serial_partner.sv]
`timescale 1ns/1ns
module serial_partner #(
    parameter int BIT_CLKS = 16
) (
    input wire logic clk_sys_in,
    input wire logic line_in,
    input wire logic send_in,
    input wire logic [11:0] frame_in,
    output logic line_out,
    output logic got_out,
    output logic [7:0] got_word_out
);
    logic [11:0] frame_q;
    logic [7:0] word_q;
    initial begin
        line_out = 1'b1;
        got_out = 1'b0;
        got_word_out = 8'h00;
    end
    always begin
        @(posedge clk_sys_in);
        if (send_in === 1'b1) begin
            frame_q = frame_in;
            for (int i = 0; i < 12; i++) begin
                line_out <= frame_q[i];
                repeat (BIT_CLKS) @(posedge clk_sys_in);
            end
        end
    end
    // mid-bit capture of the device line
    always begin
        @(negedge line_in);
        repeat (BIT_CLKS + BIT_CLKS / 2) @(posedge clk_sys_in);
        for (int i = 0; i < 8; i++) begin
            word_q[i] = line_in;
            repeat (BIT_CLKS) @(posedge clk_sys_in);
        end
        got_word_out <= word_q;
        got_out <= 1'b1;
        @(posedge clk_sys_in);
        got_out <= 1'b0;
    end
endmodule

// [testbench/test_async_serial_tx_rx_core.sv]
`timescale 1ns/1ns
module test_async_serial_tx_rx_core;
    import async_serial_pkg::*;
    logic clk_sys_in, rst_n_in, ce_in, wr_in, rd_in, rx_pin_in, tx_pin_out, tx_pin_oe_out;
    logic tx_irq_out, rx_irq_out, send, got;
    logic [2:0] addr_in;
    logic [15:0] wdata_in, rdata_out;
    logic [11:0] frame;
    logic [7:0] got_word;
    logic [7:0] got_q[$];
    int err_total, samples_checked, tx_irqs, rx_irqs, cycles;

    async_serial_tx_rx_core #(.FIFO_DEPTH(4)) u_dut (.clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in), .ce_in(ce_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .rx_pin_in(rx_pin_in),
        .tx_pin_out(tx_pin_out), .tx_pin_oe_out(tx_pin_oe_out),
        .tx_irq_out(tx_irq_out), .rx_irq_out(rx_irq_out));
    serial_partner #(.BIT_CLKS(16)) u_remote (.clk_sys_in(clk_sys_in), .line_in(tx_pin_out),
        .send_in(send), .frame_in(frame), .line_out(rx_pin_in), .got_out(got),
        .got_word_out(got_word));

    initial begin
        clk_sys_in = 1'b0;
        forever #10 clk_sys_in = ~clk_sys_in;
    end
    always @(posedge clk_sys_in) begin
        cycles++;
        if (tx_irq_out === 1'b1)
            tx_irqs++;
        if (rx_irq_out === 1'b1)
            rx_irqs++;
        if (got === 1'b1)
            got_q.push_back(got_word);
        if (cycles == 20000) begin
            err_total++;
            summarize();
        end
    end

    task automatic check_val(input logic [15:0] got_v, input logic [15:0] exp_v);
        samples_checked++;
        if (got_v !== exp_v) begin
            err_total++;
            $display("ERROR at %0t: got %h expected %h", $time, got_v, exp_v);
        end
    endtask
    task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk_sys_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge clk_sys_in);
        wr_in <= 1'b0;
    endtask
    task automatic rd_chk(input logic [2:0] a, input logic [15:0] m, input logic [15:0] e);
        @(posedge clk_sys_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge clk_sys_in);
        rd_in <= 1'b0;
        #1 check_val(rdata_out & m, e);
    endtask
    task automatic send_word(input logic [8:0] w, input int nb, input logic stop);
        logic [11:0] f;
        f = 12'hFFF;
        f[0] = 1'b0;
        for (int i = 0; i < nb; i++)
            f[i + 1] = w[i];
        f[nb + 1] = stop;
        @(posedge clk_sys_in);
        send <= 1'b1;
        frame <= f;
        @(posedge clk_sys_in);
        send <= 1'b0;
        repeat (200) @(posedge clk_sys_in);
    endtask
    task automatic wait_got(input int n);
        for (int i = 0; i < 2000 && got_q.size() < n; i++)
            @(posedge clk_sys_in);
        repeat (40) @(posedge clk_sys_in);
    endtask
    task automatic summarize();
        $display("compared %0d values, %0d mismatches", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        ce_in = 1'b1;
        rst_n_in = 1'b0;
        wr_in = 1'b0;
        rd_in = 1'b0;
        addr_in = 3'h0;
        wdata_in = 16'h0000;
        send = 1'b0;
        frame = 12'hFFF;
        repeat (10) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        rd_chk(ADDR_MODE, 16'hFFFF, MODE_RESET);
        rd_chk(ADDR_STATUS, 16'hFFFF, 16'h0110);
        rd_chk(ADDR_BAUD, 16'hFFFF, BAUD_RESET);
        rd_chk(3'h5, 16'hFFFF, 16'h0000);
        wr_reg(ADDR_MODE, 16'h8000);
        wr_reg(ADDR_TX_DATA, 16'h00A5);
        repeat (60) @(posedge clk_sys_in);
        check_val(16'(got_q.size()), 16'h0000);
        wr_reg(ADDR_STATUS, 16'h0400);
        repeat (3) @(posedge clk_sys_in);
        #1 check_val({15'h0000, tx_pin_out}, 16'h0000);
        wait_got(1);
        check_val({8'h00, got_q[0]}, 16'h00A5);
        check_val(16'(tx_irqs), 16'h0001);
        // six words into a five-deep path, last one dropped
        wr_reg(ADDR_STATUS, 16'h8400);
        got_q.delete();
        for (int i = 1; i <= 6; i++)
            wr_reg(ADDR_TX_DATA, 16'(i));
        rd_chk(ADDR_STATUS, 16'h0200, 16'h0200);
        tx_irqs = 0;
        wait_got(6);
        check_val(16'(got_q.size()), 16'h0005);
        for (int i = 0; i < 5; i++)
            check_val({8'h00, got_q[i]}, 16'(i + 1));
        check_val(16'(tx_irqs), 16'h0001);
        rd_chk(ADDR_STATUS, 16'h0300, 16'h0100);
        // break held 14 bit times, then stop time
        tx_irqs = 0;
        wr_reg(ADDR_STATUS, 16'h0C00);
        repeat (224) @(posedge clk_sys_in);
        rd_chk(ADDR_STATUS, 16'h0800, 16'h0800);
        check_val({15'h0000, tx_pin_out}, 16'h0000);
        wr_reg(ADDR_STATUS, 16'h0480);
        repeat (48) @(posedge clk_sys_in);
        check_val(16'(tx_irqs), 16'h0000);
        // receive irq at three words
        rx_irqs = 0;
        send_word(9'h011, 8, 1'b1);
        send_word(9'h022, 8, 1'b1);
        check_val(16'(rx_irqs), 16'h0000);
        send_word(9'h033, 8, 1'b1);
        check_val(16'(rx_irqs), 16'h0001);
        rd_chk(ADDR_STATUS, 16'h0011, 16'h0011);
        rd_chk(ADDR_RX_DATA, 16'h01FF, 16'h0011);
        rd_chk(ADDR_RX_DATA, 16'h01FF, 16'h0022);
        rd_chk(ADDR_RX_DATA, 16'h01FF, 16'h0033);
        rd_chk(ADDR_STATUS, 16'h0001, 16'h0000);
        rd_chk(ADDR_RX_DATA, 16'h01FF, 16'h0033);
        // even parity: bad parity word, then bad stop word
        wr_reg(ADDR_STATUS, 16'h0400);
        wr_reg(ADDR_MODE, 16'h8002);
        send_word(9'h15A, 9, 1'b1);
        send_word(9'h03C, 9, 1'b0);
        rd_chk(ADDR_STATUS, 16'h000D, 16'h0009);
        rd_chk(ADDR_RX_DATA, 16'h00FF, 16'h005A);
        rd_chk(ADDR_STATUS, 16'h000D, 16'h0005);
        rd_chk(ADDR_RX_DATA, 16'h00FF, 16'h003C);
        // overrun on the fifth word, then recovery
        wr_reg(ADDR_MODE, 16'h8000);
        for (int i = 0; i < 5; i++)
            send_word(9'(9'h040 + i), 8, 1'b1);
        rd_chk(ADDR_STATUS, 16'h0003, 16'h0003);
        wr_reg(ADDR_STATUS, 16'h0400);
        for (int i = 0; i < 5; i++)
            rd_chk(ADDR_RX_DATA, 16'h01FF, 16'(16'h0040 + i));
        // loopback: line still driven, word comes back
        wr_reg(ADDR_MODE, 16'h8046);
        got_q.delete();
        wr_reg(ADDR_TX_DATA, 16'h0196);
        wait_got(1);
        check_val({8'h00, got_q[0]}, 16'h0096);
        rd_chk(ADDR_RX_DATA, 16'h01FF, 16'h0196);
        summarize();
    end
endmodule
